// [shared/t1p_pkg.sv]
// Purpose: Constants for the single-pair PMA control, status and test-pattern registers
// Assumes: Management access uses a device address and a 16-bit register address
// Notes: Line symbols are ternary and coded in two bits
package t1p_pkg;
  // Management space of this block
  localparam logic [4:0] DEV_ADDR = 5'h01;
  localparam logic [15:0] ADDR_CTRL = 16'h08f6;
  localparam logic [15:0] ADDR_CAP = 16'h08f7;
  localparam logic [15:0] ADDR_TEST = 16'h08f8;
  localparam logic [15:0] ADDR_ROLE = 16'h0834;
  // Control register fields
  localparam int CTRL_OFF_BIT = 14;
  localparam int CTRL_HI_BIT = 12;
  localparam int CTRL_SPARE_BIT = 11;
  localparam int CTRL_EEE_BIT = 10;
  localparam int CTRL_LOOP_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Capability register fields and fixed value
  localparam int CAP_LOOP_BIT = 13;
  localparam int CAP_HI_BIT = 12;
  localparam int CAP_PD_BIT = 11;
  localparam int CAP_EEE_BIT = 10;
  localparam logic [15:0] CAP_FIXED = 16'h2800;
  // Test register field
  localparam int TEST_LSB = 13;
  localparam logic [15:0] TEST_RESET = 16'h0000;
  // Role register fields
  localparam int ROLE_BIT = 4;
  localparam logic [3:0] ROLE_TYPE = 4'h2;
  // Test pattern codes
  localparam logic [2:0] TM_NORMAL = 3'h0;
  localparam logic [2:0] TM_ALT = 3'h1;
  localparam logic [2:0] TM_DROOP = 3'h2;
  localparam logic [2:0] TM_IDLE = 3'h3;
  // Droop pattern: run length of each polarity and last count of the 20-symbol period
  localparam logic [4:0] DROOP_HALF = 5'h0a;
  localparam logic [4:0] DROOP_LAST = 5'h13;
  // Ternary symbol codes
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_POS = 2'h1;
  localparam logic [1:0] SYM_NEG = 2'h3;
  // Strap settle: two synchroniser stages plus one
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  // Register selector
  typedef enum logic [2:0] {
    RS_NONE = 3'b000,
    RS_CTRL = 3'b001,
    RS_CAP = 3'b010,
    RS_TEST = 3'b011,
    RS_ROLE = 3'b100
  } t1p_sel_t;
  // Start-up state
  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN = 1'b1
  } t1p_state_t;
endpackage : t1p_pkg

// [core/t1p_pma_regs.sv]
// Purpose: PMA line control, capability and transmit test-pattern registers with datapath
// Assumes: Management port and symbol paths run on sys_clk_in; straps are asynchronous pins
// Notes: All outputs are registered; ce_in low freezes every flip-flop
`timescale 1ns/1ns
module t1p_pma_regs #(
  parameter bit FIRST_PORT = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic mgmt_req_in,
  input wire logic mgmt_wr_in,
  input wire logic [4:0] mgmt_dev_in,
  input wire logic [15:0] mgmt_addr_in,
  input wire logic [15:0] mgmt_wdata_in,
  input wire logic tx_level_strap_in,
  input wire logic an_enable_in,
  input wire logic an_high_amplitude_in,
  input wire logic an_leader_in,
  input wire logic [1:0] tx_sym_in,
  input wire logic [1:0] line_rx_sym_in,
  output logic mgmt_ack_out,
  output logic [15:0] mgmt_rdata_out,
  output logic [1:0] line_sym_out,
  output logic line_drive_en_out,
  output logic amplitude_high_out,
  output logic leader_out,
  output logic send_idle_out,
  output logic [1:0] rx_sym_out
);
  import t1p_pkg::*;

  // Register decode, shared by read and write paths
  function automatic t1p_sel_t reg_sel(input logic [4:0] dev, input logic [15:0] addr);
    reg_sel = RS_NONE;
    if (dev == DEV_ADDR) begin
      case (addr)
        ADDR_CTRL: reg_sel = RS_CTRL;
        ADDR_CAP: reg_sel = RS_CAP;
        ADDR_TEST: reg_sel = RS_TEST;
        ADDR_ROLE: reg_sel = RS_ROLE;
        default: reg_sel = RS_NONE;
      endcase
    end
  endfunction : reg_sel

  // Strap synchroniser; stage one feeds only stage two
  logic strap_s1_ff, strap_s2_ff;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_s1_ff <= 1'b0;
      strap_s2_ff <= 1'b0;
    end else if (ce_in) begin
      strap_s1_ff <= tx_level_strap_in;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // Register state
  t1p_state_t st_ff, nxt_st;
  logic [1:0] wait_ff, nxt_wait;
  logic cap_hi_ff, nxt_cap_hi;
  logic off_ff, nxt_off;
  logic hi_sel_ff, nxt_hi_sel;
  logic spare_ff, nxt_spare;
  logic eee_ff, nxt_eee;
  logic loop_ff, nxt_loop;
  logic [2:0] tmode_ff, nxt_tmode;
  logic role_ff, nxt_role;
  logic ack_ff, nxt_ack;
  logic [15:0] rdata_ff, nxt_rdata;
  t1p_sel_t sel;

  // Management read/write and strap capture after reset release
  always_comb begin
    sel = reg_sel(mgmt_dev_in, mgmt_addr_in);
    nxt_st = st_ff;
    nxt_wait = wait_ff;
    nxt_cap_hi = cap_hi_ff;
    nxt_off = off_ff;
    nxt_hi_sel = hi_sel_ff;
    nxt_spare = spare_ff;
    nxt_eee = eee_ff;
    nxt_loop = loop_ff;
    nxt_tmode = tmode_ff;
    nxt_role = role_ff;
    nxt_ack = mgmt_req_in;
    nxt_rdata = 16'h0000;
    // Strap is read only once it has crossed both stages
    if (st_ff == ST_WAIT) begin
      if (wait_ff == STRAP_WAIT) begin
        nxt_cap_hi = strap_s2_ff;
        nxt_hi_sel = strap_s2_ff;
        nxt_st = ST_RUN;
      end else begin
        nxt_wait = wait_ff + 2'h1;
      end
    end
    if (mgmt_req_in && mgmt_wr_in) begin
      // Only writable fields are loaded; capability writes fall away
      case (sel)
        RS_CTRL: begin
          nxt_off = mgmt_wdata_in[CTRL_OFF_BIT];
          nxt_hi_sel = mgmt_wdata_in[CTRL_HI_BIT];
          nxt_spare = mgmt_wdata_in[CTRL_SPARE_BIT];
          nxt_eee = mgmt_wdata_in[CTRL_EEE_BIT];
          nxt_loop = mgmt_wdata_in[CTRL_LOOP_BIT];
        end
        RS_TEST: nxt_tmode = mgmt_wdata_in[TEST_LSB +: 3];
        RS_ROLE: nxt_role = mgmt_wdata_in[ROLE_BIT];
        default: nxt_rdata = 16'h0000;
      endcase
    end else if (mgmt_req_in) begin
      case (sel)
        RS_CTRL: begin
          nxt_rdata[CTRL_OFF_BIT] = off_ff;
          nxt_rdata[CTRL_HI_BIT] = hi_sel_ff;
          nxt_rdata[CTRL_SPARE_BIT] = spare_ff;
          nxt_rdata[CTRL_EEE_BIT] = eee_ff;
          nxt_rdata[CTRL_LOOP_BIT] = loop_ff;
        end
        RS_CAP: begin
          nxt_rdata = CAP_FIXED;
          nxt_rdata[CAP_HI_BIT] = cap_hi_ff;
        end
        RS_TEST: nxt_rdata[TEST_LSB +: 3] = tmode_ff;
        RS_ROLE: begin
          nxt_rdata[3:0] = ROLE_TYPE;
          nxt_rdata[ROLE_BIT] = role_ff;
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff <= ST_WAIT;
      wait_ff <= 2'h0;
      cap_hi_ff <= 1'b0;
      off_ff <= CTRL_RESET[CTRL_OFF_BIT];
      hi_sel_ff <= CTRL_RESET[CTRL_HI_BIT];
      spare_ff <= CTRL_RESET[CTRL_SPARE_BIT];
      eee_ff <= CTRL_RESET[CTRL_EEE_BIT];
      loop_ff <= CTRL_RESET[CTRL_LOOP_BIT];
      tmode_ff <= TEST_RESET[TEST_LSB +: 3];
      role_ff <= FIRST_PORT;
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else if (ce_in) begin
      st_ff <= nxt_st;
      wait_ff <= nxt_wait;
      cap_hi_ff <= nxt_cap_hi;
      off_ff <= nxt_off;
      hi_sel_ff <= nxt_hi_sel;
      spare_ff <= nxt_spare;
      eee_ff <= nxt_eee;
      loop_ff <= nxt_loop;
      tmode_ff <= nxt_tmode;
      role_ff <= nxt_role;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Line datapath state
  logic [4:0] cnt_ff, nxt_cnt;
  logic [1:0] sym_ff, nxt_sym;
  logic drv_ff, nxt_drv;
  logic amp_ff, nxt_amp;
  logic lead_ff, nxt_lead;
  logic idle_ff, nxt_idle;
  logic [1:0] rx_ff, nxt_rx;

  // Pattern generation, amplitude, role and loopback; energy-saving bit is not read here
  always_comb begin
    nxt_cnt = (cnt_ff == DROOP_LAST) ? 5'h00 : cnt_ff + 5'h01;
    nxt_sym = tx_sym_in;
    nxt_idle = 1'b0;
    nxt_lead = an_enable_in ? an_leader_in : role_ff;
    case (tmode_ff)
      TM_ALT: nxt_sym = cnt_ff[0] ? SYM_NEG : SYM_POS;
      TM_DROOP: nxt_sym = (cnt_ff < DROOP_HALF) ? SYM_POS : SYM_NEG;
      TM_IDLE: begin
        nxt_idle = 1'b1;
        nxt_lead = 1'b1;
      end
      default: nxt_cnt = 5'h00; // Upper codes run as normal
    endcase
    // Silencing overrides every pattern, the driver is released too
    nxt_drv = !off_ff;
    if (off_ff) begin
      nxt_sym = SYM_ZERO;
    end
    nxt_amp = an_enable_in ? an_high_amplitude_in : hi_sel_ff;
    nxt_rx = loop_ff ? tx_sym_in : line_rx_sym_in;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_ff <= 5'h00;
      sym_ff <= SYM_ZERO;
      drv_ff <= 1'b0;
      amp_ff <= 1'b0;
      lead_ff <= 1'b0;
      idle_ff <= 1'b0;
      rx_ff <= SYM_ZERO;
    end else if (ce_in) begin
      cnt_ff <= nxt_cnt;
      sym_ff <= nxt_sym;
      drv_ff <= nxt_drv;
      amp_ff <= nxt_amp;
      lead_ff <= nxt_lead;
      idle_ff <= nxt_idle;
      rx_ff <= nxt_rx;
    end
  end

  // Outputs straight from flip-flops
  assign mgmt_ack_out = ack_ff;
  assign mgmt_rdata_out = rdata_ff;
  assign line_sym_out = sym_ff;
  assign line_drive_en_out = drv_ff;
  assign amplitude_high_out = amp_ff;
  assign leader_out = lead_ff;
  assign send_idle_out = idle_ff;
  assign rx_sym_out = rx_ff;

  // Checks on the registered behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  // The release edge still runs the reset branch, so output checks start one edge later
  line_silence_a: assert property (
    ce_in && off_ff |=> !line_drive_en_out && line_sym_out == SYM_ZERO)
    else $error("line not silenced");
  drive_on_a: assert property (
    rstn_in && ce_in && !off_ff |=> line_drive_en_out)
    else $error("line driver not enabled");
  manual_amp_a: assert property (
    rstn_in && ce_in && !an_enable_in |=> amplitude_high_out == $past(hi_sel_ff))
    else $error("manual amplitude wrong");
  an_amp_a: assert property (
    rstn_in && ce_in && an_enable_in |=> amplitude_high_out == $past(an_high_amplitude_in))
    else $error("negotiated amplitude wrong");
  loopback_path_a: assert property (
    rstn_in && ce_in && loop_ff |=> rx_sym_out == $past(tx_sym_in))
    else $error("loopback path wrong");
  rx_normal_a: assert property (
    rstn_in && ce_in && !loop_ff |=> rx_sym_out == $past(line_rx_sym_in))
    else $error("line receive path wrong");
  cap_fixed_a: assert property (
    ce_in && mgmt_req_in && !mgmt_wr_in && reg_sel(mgmt_dev_in, mgmt_addr_in) == RS_CAP
    |=> mgmt_ack_out && mgmt_rdata_out[CAP_LOOP_BIT] && mgmt_rdata_out[CAP_PD_BIT]
    && !mgmt_rdata_out[CAP_EEE_BIT])
    else $error("fixed capability bits wrong");
  cap_strap_a: assert property (
    ce_in && mgmt_req_in && !mgmt_wr_in && reg_sel(mgmt_dev_in, mgmt_addr_in) == RS_CAP
    |=> mgmt_rdata_out[CAP_HI_BIT] == $past(cap_hi_ff))
    else $error("high amplitude capability wrong");
  normal_mode_a: assert property (
    rstn_in && ce_in && tmode_ff == TM_NORMAL && !off_ff
    |=> line_sym_out == $past(tx_sym_in) && !send_idle_out)
    else $error("normal mode not transparent");
  alt_pattern_a: assert property (
    ce_in && tmode_ff == TM_ALT && !off_ff ##1 ce_in && tmode_ff == TM_ALT && !off_ff
    |=> line_sym_out != $past(line_sym_out))
    else $error("alternating pattern broken");
  droop_pattern_a: assert property (
    ce_in && tmode_ff == TM_DROOP && !off_ff
    |=> line_sym_out == (($past(cnt_ff) < DROOP_HALF) ? SYM_POS : SYM_NEG))
    else $error("droop pattern wrong");
  idle_mode_a: assert property (
    ce_in && tmode_ff == TM_IDLE |=> send_idle_out && leader_out)
    else $error("idle test mode wrong");
  idle_off_a: assert property (
    ce_in && tmode_ff != TM_IDLE |=> !send_idle_out)
    else $error("idle request outside test mode");
  eee_store_a: assert property (
    rstn_in && ce_in && mgmt_req_in && mgmt_wr_in
    && reg_sel(mgmt_dev_in, mgmt_addr_in) == RS_CTRL
    |=> eee_ff == $past(mgmt_wdata_in[CTRL_EEE_BIT]))
    else $error("energy-saving enable not stored");
  upper_code_a: assert property (
    rstn_in && ce_in && tmode_ff[2] && !off_ff
    |=> line_sym_out == $past(tx_sym_in) && !send_idle_out)
    else $error("undefined test code not normal");
  unmapped_read_a: assert property (
    ce_in && mgmt_req_in && reg_sel(mgmt_dev_in, mgmt_addr_in) == RS_NONE
    |=> mgmt_rdata_out == 16'h0000)
    else $error("unmapped access returned data");
  read_ack_a: assert property (
    rstn_in && ce_in |=> mgmt_ack_out == $past(mgmt_req_in))
    else $error("access not acknowledged once");
  role_select_a: assert property (
    rstn_in && ce_in && !an_enable_in && tmode_ff != TM_IDLE |=> leader_out == $past(role_ff))
    else $error("manual role not applied");
  an_role_a: assert property (
    rstn_in && ce_in && an_enable_in && tmode_ff != TM_IDLE
    |=> leader_out == $past(an_leader_in))
    else $error("negotiated role not applied");

  alt_seen_c: cover property (ce_in && tmode_ff == TM_ALT ##1 ce_in && tmode_ff == TM_ALT);
  droop_wrap_c: cover property (ce_in && tmode_ff == TM_DROOP && cnt_ff == DROOP_LAST);
  loop_seen_c: cover property (ce_in && loop_ff && !off_ff);
  strap_done_c: cover property (st_ff == ST_WAIT ##1 st_ff == ST_RUN);
  unmapped_c: cover property (
    ce_in && mgmt_req_in && reg_sel(mgmt_dev_in, mgmt_addr_in) == RS_NONE);
endmodule : t1p_pma_regs

// [verif/t1p_remote_phy.sv]
// Purpose: Far-end PHY on the cable, feeding received line symbols
// Assumes: One symbol per system clock edge
// Notes: Symbol changes every cycle so a stale value is never mistaken for a fresh one
`timescale 1ns/1ns
module t1p_remote_phy (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  output logic [1:0] line_rx_sym_out
);
  import t1p_pkg::*;
  // Rotate zero, plus one, minus one so consecutive symbols always differ
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_rx_sym_out <= SYM_ZERO;
    end else if (line_rx_sym_out == SYM_ZERO) begin
      line_rx_sym_out <= SYM_POS;
    end else if (line_rx_sym_out == SYM_POS) begin
      line_rx_sym_out <= SYM_NEG;
    end else begin
      line_rx_sym_out <= SYM_ZERO;
    end
  end
endmodule : t1p_remote_phy

// [verif/t1l_pma_control_status_test_tb_top.sv]
// Purpose: Self-checking bench for the PMA control, capability and test-pattern block
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes: Clock enable drops once to show that the running pattern freezes
`timescale 1ns/1ns
module t1l_pma_control_status_test_tb_top;
  import t1p_pkg::*;
  logic sys_clk_in, rstn_in, ce, req, wr, strap, an_en, an_hi, an_ld;
  logic ack, drv_en, amp_hi, leader, idle;
  logic [4:0] dev;
  logic [15:0] addr, wdata, rdata, rd, wd;
  logic [1:0] tx_sym, rx_line, lsym, rxs, txs, rxl, hold;
  logic [2:0] code;
  int seed, error_cnt, checked, r, rs;
  t1p_pma_regs #(.FIRST_PORT(1'b1)) DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .ce_in(ce), .mgmt_req_in(req), .mgmt_wr_in(wr), .mgmt_dev_in(dev),
    .mgmt_addr_in(addr), .mgmt_wdata_in(wdata), .tx_level_strap_in(strap),
    .an_enable_in(an_en), .an_high_amplitude_in(an_hi), .an_leader_in(an_ld),
    .tx_sym_in(tx_sym), .line_rx_sym_in(rx_line), .mgmt_ack_out(ack),
    .mgmt_rdata_out(rdata), .line_sym_out(lsym), .line_drive_en_out(drv_en),
    .amplitude_high_out(amp_hi), .leader_out(leader), .send_idle_out(idle),
    .rx_sym_out(rxs));
  t1p_remote_phy far_end (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .line_rx_sym_out(rx_line));
  // Clock at 100 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // Random transmit symbols every cycle; code 2 is not a legal symbol, so map it to zero
  // Own variable, so the scenario's random fields are not overwritten every edge
  always @(posedge sys_clk_in) begin
    rs = $random(seed);
    tx_sym <= (rs[1:0] == 2'h2) ? SYM_ZERO : rs[1:0];
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One management access; answer is taken one cycle after the request
  task automatic acc(input logic w, input logic [4:0] d, input logic [15:0] a,
                     input logic [15:0] v);
    @(posedge sys_clk_in);
    req <= 1'b1;
    wr <= w;
    dev <= d;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk_in);
    req <= 1'b0;
    #1;
    chk("ack", 16'h0001, {15'h0000, ack});
    rd = rdata;
  endtask : acc
  // Sample the symbols the design sees at this edge, then let outputs settle
  task automatic tick;
    @(posedge sys_clk_in);
    txs = tx_sym;
    rxl = rx_line;
    #1;
  endtask : tick
  // Expected line symbol for a test code at pattern position n
  function automatic logic [1:0] pat(input logic [2:0] c, input int n, input logic [1:0] t);
    if (c == TM_ALT) return (n % 2 == 0) ? SYM_POS : SYM_NEG;
    if (c == TM_DROOP) return (n % 20 < 10) ? SYM_POS : SYM_NEG;
    return t;
  endfunction : pat
  task stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    #300_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    seed = 32'hb1b4;
    error_cnt = 0;
    checked = 0;
    r = $random(seed);
    strap = r[0];
    {req, wr, an_en, an_hi, an_ld} = 5'h00;
    dev = 5'h00;
    addr = 16'h0000;
    wdata = 16'h0000;
    tx_sym = SYM_ZERO;
    ce = 1'b1;
    rstn_in = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    // Strap capture needs a few edges before the first access
    repeat (4) @(posedge sys_clk_in);
    acc(1'b0, DEV_ADDR, ADDR_CTRL, 16'h0000);
    chk("ctrl reset", {3'h0, strap, 12'h000}, rd);
    acc(1'b0, DEV_ADDR, ADDR_CAP, 16'h0000);
    chk("capability", {3'h1, strap, 12'h800}, rd);
    acc(1'b0, DEV_ADDR, ADDR_TEST, 16'h0000);
    chk("test reset", 16'h0000, rd);
    // Writes to the read-only word and to a foreign device change nothing
    acc(1'b1, DEV_ADDR, ADDR_CAP, 16'hffff);
    acc(1'b1, 5'h02, ADDR_CTRL, 16'hffff);
    acc(1'b0, DEV_ADDR, ADDR_CAP, 16'h0000);
    chk("capability kept", {3'h1, strap, 12'h800}, rd);
    acc(1'b0, DEV_ADDR, ADDR_CTRL, 16'h0000);
    chk("ctrl kept", {3'h0, strap, 12'h000}, rd);
    // Control word: corner values first, then random ones
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      wd = (i == 0) ? 16'h4000 : (i == 1) ? 16'h1001 : (i == 2) ? 16'hffff : r[15:0];
      @(posedge sys_clk_in);
      an_en <= r[16];
      an_hi <= r[17];
      an_ld <= r[18];
      acc(1'b1, DEV_ADDR, ADDR_CTRL, wd);
      for (int k = 0; k < 3; k++) begin
        tick();
        chk("drive enable", {15'h0000, ~wd[14]}, {15'h0000, drv_en});
        chk("line symbol", {14'h0, wd[14] ? SYM_ZERO : txs}, {14'h0, lsym});
        chk("amplitude", {15'h0, r[16] ? r[17] : wd[12]}, {15'h0, amp_hi});
        chk("receive", {14'h0000, wd[0] ? txs : rxl}, {14'h0000, rxs});
        chk("role", {15'h0000, r[16] ? r[18] : 1'b1}, {15'h0000, leader});
      end
      acc(1'b0, DEV_ADDR, ADDR_CTRL, 16'h0000);
      chk("ctrl readback", wd & 16'h5c01, rd);
    end
    // Test codes 1 to 7, with negotiation choosing follower to expose the forced leader
    @(posedge sys_clk_in);
    an_en <= 1'b1;
    an_ld <= 1'b0;
    acc(1'b1, DEV_ADDR, ADDR_CTRL, 16'h0000);
    for (int c = 1; c < 8; c++) begin
      code = c[2:0];
      acc(1'b1, DEV_ADDR, ADDR_TEST, {code, 13'h1fff});
      for (int n = 0; n < 24; n++) begin
        tick();
        chk("pattern", {14'h0, pat(code, n, txs)}, {14'h0, lsym});
        chk("idle", {15'h0000, code == TM_IDLE}, {15'h0000, idle});
        chk("leader", {15'h0000, code == TM_IDLE}, {15'h0000, leader});
      end
      acc(1'b0, DEV_ADDR, ADDR_TEST, 16'h0000);
      chk("test readback", {code, 13'h0000}, rd);
      acc(1'b1, DEV_ADDR, ADDR_TEST, 16'h0000);
    end
    // Freeze: with the enable low the running pattern must hold still
    acc(1'b1, DEV_ADDR, ADDR_TEST, {TM_ALT, 13'h0000});
    @(posedge sys_clk_in);
    ce <= 1'b0;
    #1;
    hold = lsym;
    repeat (4) begin
      tick();
      chk("frozen symbol", {14'h0, hold}, {14'h0, lsym});
    end
    @(posedge sys_clk_in);
    ce <= 1'b1;
    // Role word: port reset value, manual follower, then negotiation takes over
    acc(1'b0, DEV_ADDR, ADDR_ROLE, 16'h0000);
    chk("role reset", {11'h000, 1'b1, ROLE_TYPE}, rd);
    @(posedge sys_clk_in);
    an_en <= 1'b0;
    an_ld <= 1'b1;
    acc(1'b1, DEV_ADDR, ADDR_ROLE, 16'h0000);
    tick();
    chk("manual follower", 16'h0000, {15'h0, leader});
    @(posedge sys_clk_in);
    an_en <= 1'b1;
    tick();
    chk("negotiated leader", 16'h0001, {15'h0, leader});
    acc(1'b0, 5'h02, ADDR_TEST, 16'h0000);
    chk("foreign read", 16'h0000, rd);
    stop_test();
  end
endmodule : t1l_pma_control_status_test_tb_top
